// ### hdl/dss_sequencer.sv
// Dual slope switch sequencer: drives the eight analog switch controls
// of an integrating converter front end and counts its reference ramp.
// Assumes comparator input synchronous to ref_clk and one clock domain.
// Phase lengths come from parameters; timing figures from the map.
`include "dss_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Offset correction closes five zeroing switches.
// - Polarity closes only ground and direct switches.
// - Polarity end swaps direct for buffer path.
// - Comparator level before polarity end gives sign.
// - Initialization repeats offset correction switch set.
// - Positive ramp unknown: direct plus ground switch.
// - Negative ramp unknown: buffered plus integrator switch.
// - Ramp reference holds until comparator trips or count reaches full scale.
// - Ramp unknown lasts exactly 4096 clock periods.
// - Count reference ramp periods as result.
// - Output polarity and overrange besides magnitude.
// - Start accepted only after 2.4 us high.
// - Delay rising switch edges, falling immediate.
// - Slower clock lowers residual offset, optional.
// - Zeroing cycle lasts 256 clock periods.
module dss_sequencer
  import dss_pkg::*;
#(
  parameter int RU_PERIODS = `DSS_RAMP_UNKNOWN_PERIODS,
  parameter int ZERO_PERIODS = `DSS_ZERO_PERIODS,
  parameter int POL_PERIODS = 128,
  parameter int RES_BITS = 12
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic comparator_out,
  output logic reference_switch,
  output logic buffered_unknown_switch,
  output logic direct_unknown_switch,
  output logic buffer_to_integrator_switch,
  output logic buffer_ground_switch,
  output logic resistor_bypass_switch,
  output logic unity_gain_switch,
  output logic comparator_loop_switch,
  output logic [RES_BITS-1:0] magnitude,
  output logic polarity,
  output logic overrange,
  output logic busy,
  output logic done
);

  // ==========================================================
  // Derived sizes
  localparam int CW = RES_BITS + 1;
  // Cycle counts follow the clock rate; a slower clock only shrinks them
  localparam int START_CYC = `DSS_START_CYC;
  localparam int BREAK_CYC = `DSS_BREAK_CYC;
  // Initialization takes the rest of the zeroing budget
  localparam int INIT_PERIODS = ZERO_PERIODS - POL_PERIODS;

  // ==========================================================
  // Elaboration checks
  // The unknown ramp must span the full magnitude range
  initial begin
    if (RU_PERIODS != (1 << RES_BITS)) begin
      $error("dss_sequencer: ramp length must be two to the width");
    end
  end

  // Polarity must leave room for initialization afterwards
  initial begin
    if (ZERO_PERIODS < 4 || POL_PERIODS < 2 ||
        POL_PERIODS >= ZERO_PERIODS - 1) begin
      $error("dss_sequencer: zeroing split unsupported");
    end
  end

  // A phase shorter than the break delay never closes its switches, so
  // the sign would be sampled before any integration took place
  initial begin
    if (POL_PERIODS < BREAK_CYC + 3 || INIT_PERIODS < BREAK_CYC + 3) begin
      $error("dss_sequencer: phase shorter than the break delay");
    end
  end

  // Phase counter and the small delay counters must hold their limits
  initial begin
    if (ZERO_PERIODS > (1 << CW) || START_CYC > 62 || BREAK_CYC > 14) begin
      $error("dss_sequencer: counters too narrow for these settings");
    end
  end

  // ==========================================================
  // Start qualification
  // start is a level; it must stay high for the minimum width before a
  // conversion is taken, which also filters glitches on the line
  logic [5:0] start_cnt;
  logic start_ok;
  wire start_full = (start_cnt >= 6'(START_CYC));

  // Count high time; short glitches are dropped
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_cnt <= 6'h00;
    end else if (!start) begin
      start_cnt <= 6'h00;
    end else if (!start_full) begin
      start_cnt <= start_cnt + 6'h01;
    end
  end

  // Accept in every idle cycle while held, so a stuck-high start loops conversions
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_ok <= 1'b0;
    end else begin
      start_ok <= start_full;
    end
  end

  // ==========================================================
  // Phase sequencer
  // One counter times every phase; it restarts at each phase change, so
  // the compare constants are the phase lengths less one. Sharing it
  // keeps the flop count down at the cost of one wide compare per phase.
  dss_phase_t phase;
  dss_phase_t next_phase;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic sign;
  wire [CW-1:0] ru_last = CW'(RU_PERIODS - 1);
  wire [CW-1:0] ref_full = CW'(RU_PERIODS);

  // Next phase and counter; order fixed
  always_comb begin
    next_phase = phase;
    next_cnt = cnt + CW'(1);
    case (phase)
      DSS_IDLE: begin
        next_cnt = '0;
        if (start_ok) begin
          next_phase = DSS_OFFSET;
        end
      end
      DSS_OFFSET: begin
        if (cnt == CW'(ZERO_PERIODS - 1)) begin
          next_phase = DSS_POLARITY;
          next_cnt = '0;
        end
      end
      DSS_POLARITY: begin
        if (cnt == CW'(POL_PERIODS - 1)) begin
          next_phase = DSS_INIT;
          next_cnt = '0;
        end
      end
      DSS_INIT: begin
        if (cnt == CW'(INIT_PERIODS - 1)) begin
          next_phase = DSS_RAMP_UNK;
          next_cnt = '0;
        end
      end
      DSS_RAMP_UNK: begin
        if (cnt == ru_last) begin
          next_phase = DSS_RAMP_REF;
          next_cnt = '0;
        end
      end
      DSS_RAMP_REF: begin
        if (!comparator_out || cnt == ref_full) begin
          next_phase = DSS_IDLE;
          next_cnt = '0;
        end
      end
      default: begin
        next_phase = DSS_IDLE;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= DSS_IDLE;
      cnt <= '0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
    end
  end

  // Sign sampled in the last polarity cycle, just before the direct path
  // opens; a zero input reads low and so takes the buffered path
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sign <= 1'b0;
    end else if (phase == DSS_POLARITY && next_phase == DSS_INIT) begin
      sign <= comparator_out;
    end
  end

  // ==========================================================
  // Result capture
  // Results move only together with done, so a reader that latches on
  // done never sees a mixed word
  wire ref_end = (phase == DSS_RAMP_REF) && (next_phase == DSS_IDLE);
  wire is_over = (cnt >= ref_full);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      magnitude <= '0;
      polarity <= 1'b0;
      overrange <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
    end else begin
      done <= ref_end;
      busy <= (next_phase != DSS_IDLE);
      if (ref_end) begin
        // Saturate on overrange; reference ramp never tripped
        magnitude <= is_over ? '1 : cnt[RES_BITS-1:0];
        overrange <= is_over;
        polarity <= sign;
      end
    end
  end

  // ==========================================================
  // Switch pattern per phase; everything else open
  // A pattern is a pure function of the phase and the held sign, so a
  // comparator glitch reaches the switch drive only through the sign sampled at polarity end or by ending the reference ramp
  logic [7:0] want;
  always_comb begin
    want = 8'h00;
    case (phase)
      DSS_OFFSET, DSS_INIT: begin
        want[`DSS_SW_BUF_GND] = 1'b1;
        want[`DSS_SW_BYPASS] = 1'b1;
        want[`DSS_SW_BUF_INT] = 1'b1;
        want[`DSS_SW_UNITY] = 1'b1;
        want[`DSS_SW_CMP_LOOP] = 1'b1;
      end
      DSS_POLARITY: begin
        want[`DSS_SW_BUF_GND] = 1'b1;
        want[`DSS_SW_DIR_UNK] = 1'b1;
      end
      DSS_RAMP_UNK: begin
        if (sign) begin
          want[`DSS_SW_DIR_UNK] = 1'b1;
          want[`DSS_SW_BUF_GND] = 1'b1;
        end else begin
          want[`DSS_SW_BUF_UNK] = 1'b1;
          want[`DSS_SW_BUF_INT] = 1'b1;
        end
      end
      DSS_RAMP_REF: begin
        want[`DSS_SW_REF] = 1'b1;
        want[`DSS_SW_BUF_INT] = 1'b1;
      end
      default: begin
        want = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // Break-before-make: rising edges wait, falling edges act at once
  // At this clock the delay spans several cycles; it trims the start of
  // each closed interval, so short phases must stay longer than it.
  // One counter per switch keeps a switch that stays closed across a
  // phase change from opening at all.
  logic [7:0] sw;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_sw
      logic [3:0] dly;
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          dly <= 4'h0;
          sw[g] <= 1'b0;
        end else if (!want[g]) begin
          dly <= 4'h0;
          sw[g] <= 1'b0;
        end else if (dly == 4'(BREAK_CYC)) begin
          sw[g] <= 1'b1;
        end else begin
          dly <= dly + 4'h1;
        end
      end
    end
  endgenerate

  // Pins come straight from the per-switch flops
  assign reference_switch = sw[`DSS_SW_REF];
  assign buffered_unknown_switch = sw[`DSS_SW_BUF_UNK];
  assign direct_unknown_switch = sw[`DSS_SW_DIR_UNK];
  assign buffer_to_integrator_switch = sw[`DSS_SW_BUF_INT];
  assign buffer_ground_switch = sw[`DSS_SW_BUF_GND];
  assign resistor_bypass_switch = sw[`DSS_SW_BYPASS];
  assign unity_gain_switch = sw[`DSS_SW_UNITY];
  assign comparator_loop_switch = sw[`DSS_SW_CMP_LOOP];

endmodule

`default_nettype wire

// ### hdl/dss_map.svh
// Constants for the dual slope switch sequencer.
// Assumes a 20 MHz controller clock; included by the top.
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH

// Switch vector bit positions
`define DSS_SW_REF 0
`define DSS_SW_BUF_UNK 1
`define DSS_SW_DIR_UNK 2
`define DSS_SW_BUF_INT 3
`define DSS_SW_BUF_GND 4
`define DSS_SW_BYPASS 5
`define DSS_SW_UNITY 6
`define DSS_SW_CMP_LOOP 7

// Timing figures as printed
`define DSS_CLK_HZ 20000000
`define DSS_START_MIN_NS 2400
`define DSS_BREAK_NS 300
`define DSS_RAMP_UNKNOWN_PERIODS 4096
`define DSS_ZERO_PERIODS 256

// Derived cycle counts: least times round up
`define DSS_START_CYC \
  ((`DSS_START_MIN_NS * (`DSS_CLK_HZ / 1000000) + 999) / 1000)
`define DSS_BREAK_CYC \
  ((`DSS_BREAK_NS * (`DSS_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ### hdl/dss_pkg.sv
// Types for the dual slope switch sequencer.
// Assumes nothing beyond the map header.
package dss_pkg;
  // Conversion phases, one-hot
  typedef enum logic [5:0] {
    DSS_IDLE = 6'h01,
    DSS_OFFSET = 6'h02,
    DSS_POLARITY = 6'h04,
    DSS_INIT = 6'h08,
    DSS_RAMP_UNK = 6'h10,
    DSS_RAMP_REF = 6'h20
  } dss_phase_t;
endpackage

// ### test/dss_sequencer_asserts.sv
// Port checker for the switch sequencer.
// Assumes it is bound onto dss_sequencer.
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port checks
module dss_seq_chk #(
  parameter int RES_BITS = 12
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic comparator_out,
  input wire logic reference_switch,
  input wire logic buffered_unknown_switch,
  input wire logic direct_unknown_switch,
  input wire logic buffer_to_integrator_switch,
  input wire logic buffer_ground_switch,
  input wire logic resistor_bypass_switch,
  input wire logic unity_gain_switch,
  input wire logic comparator_loop_switch,
  input wire logic [RES_BITS-1:0] magnitude,
  input wire logic polarity,
  input wire logic overrange,
  input wire logic busy,
  input wire logic done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  int srun;
  // Length of the present run of start high
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      srun <= 0;
    end else begin
      srun <= start ? srun + 1 : 0;
    end
  end
  AST_ZERO_SET: assert property (unity_gain_switch |->
    !(reference_switch | buffered_unknown_switch | direct_unknown_switch))
    else $error("zeroing set mixed with an input path");
  AST_DIRECT: assert property (direct_unknown_switch |->
    buffer_ground_switch && !buffer_to_integrator_switch)
    else $error("direct path without ground");
  AST_BUF_PATH: assert property (buffered_unknown_switch |->
    buffer_to_integrator_switch && !buffer_ground_switch)
    else $error("buffered path set wrong");
  AST_REF_PATH: assert property (reference_switch |->
    buffer_to_integrator_switch && !buffer_ground_switch)
    else $error("reference path set wrong");
  AST_REF_STOP: assert property (reference_switch && !comparator_out
    |-> ##[1:3] !reference_switch) else $error("ramp kept past trip");
  AST_START_LEN: assert property ($rose(busy) |-> $past(srun) >= 48)
    else $error("short start accepted");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_RESULT: assert property (($changed(magnitude) ||
    $changed(polarity)) |-> done) else $error("result moved without done");
  AST_OVR_SAT: assert property (overrange |-> &magnitude)
    else $error("overrange without full scale");
  AST_ZERO_ALL: assert property (unity_gain_switch |->
    resistor_bypass_switch && comparator_loop_switch &&
    buffer_ground_switch && buffer_to_integrator_switch)
    else $error("zeroing set incomplete");
  cover property ($rose(overrange));
  cover property ($rose(buffered_unknown_switch));
  cover property ($rose(reference_switch));
endmodule
bind dss_sequencer dss_seq_chk #(.RES_BITS(RES_BITS)) u_dss_seq_chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .start(start),
  .comparator_out(comparator_out), .reference_switch(reference_switch),
  .buffered_unknown_switch(buffered_unknown_switch),
  .direct_unknown_switch(direct_unknown_switch),
  .buffer_to_integrator_switch(buffer_to_integrator_switch),
  .buffer_ground_switch(buffer_ground_switch),
  .resistor_bypass_switch(resistor_bypass_switch),
  .unity_gain_switch(unity_gain_switch),
  .comparator_loop_switch(comparator_loop_switch),
  .magnitude(magnitude), .polarity(polarity), .overrange(overrange),
  .busy(busy), .done(done));
`default_nettype wire

// ### test/dss_front_model.sv
// Behavioural integrator and comparator of the front end.
// Assumes sw bit order of the map header, high = closed.
`timescale 1ns/1ps
`default_nettype none
// ====================
// Front end model
module dss_front_model (
  input wire logic ref_clk,
  input wire logic [7:0] sw,
  input var int vx,
  input var int vref,
  output logic comparator_out
);
  int integ = 0;
  // One integration step per clock; no analog slew is modelled
  always @(posedge ref_clk) begin
    if (sw[5] & sw[6] & sw[7]) begin
      integ <= 0;
    end else if (sw[2] & sw[4]) begin
      integ <= integ + vx;
    end else if (sw[1] & sw[3]) begin
      integ <= integ - vx;
    end else if (sw[0] & sw[3]) begin
      integ <= integ - vref;
    end
  end
  // Zero counts as low, as the comparator does
  assign comparator_out = integ > 0;
endmodule
`default_nettype wire

// ### test/dss_sequencer_tb.sv
// Self-checking bench for the switch sequencer.
// Assumes the front end model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench top
module dss_sequencer_tb;
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  logic start = 1'h0;
  wire logic comparator_out;
  logic [7:0] sw;
  logic [3:0] magnitude;
  logic polarity, overrange, busy, done;
  int vx = 0;
  int vref = 8;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  always #25 ref_clk = ~ref_clk;
  // Short phases keep the run brief; each outlasts the break delay
  dss_sequencer #(.RU_PERIODS(16), .ZERO_PERIODS(32), .POL_PERIODS(16),
    .RES_BITS(4)) u_dss_sequencer (.ref_clk(ref_clk), .arst_n(arst_n),
    .start(start), .comparator_out(comparator_out),
    .reference_switch(sw[0]), .buffered_unknown_switch(sw[1]),
    .direct_unknown_switch(sw[2]), .buffer_to_integrator_switch(sw[3]),
    .buffer_ground_switch(sw[4]), .resistor_bypass_switch(sw[5]),
    .unity_gain_switch(sw[6]), .comparator_loop_switch(sw[7]),
    .magnitude(magnitude), .polarity(polarity), .overrange(overrange),
    .busy(busy), .done(done));
  dss_front_model u_dss_front_model (.ref_clk(ref_clk), .sw(sw), .vx(vx),
    .vref(vref), .comparator_out(comparator_out));
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard, well above four short conversions
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  // A start pulse below the minimum width must be ignored
  task automatic short_start;
    start = 1'h1;
    repeat (40) @(negedge ref_clk);
    start = 1'h0;
    repeat (20) @(negedge ref_clk);
    check({3'h0, busy}, 4'h0);
  endtask
  // One conversion: start held until busy, then the result judged
  // use_mag is off where the break delay makes the count timing-bound
  task automatic convert(input int v, input logic pol, input logic ovr,
    input bit use_mag, input logic [3:0] mag);
    int n;
    vx = v;
    start = 1'h1;
    for (n = 0; n < 80 && busy !== 1'h1; n++) @(negedge ref_clk);
    start = 1'h0;
    check({3'h0, busy}, 4'h1);
    for (n = 0; n < 400 && done !== 1'h1; n++) @(negedge ref_clk);
    check({3'h0, done}, 4'h1);
    check({3'h0, polarity}, {3'h0, pol});
    check({3'h0, overrange}, {3'h0, ovr});
    if (use_mag) begin
      check(magnitude, mag);
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'h1;
    @(negedge ref_clk);
    short_start();
    convert(16, 1'h1, 1'h1, 1'b1, 4'hf);
    convert(-16, 1'h0, 1'h1, 1'b1, 4'hf);
    convert(1, 1'h1, 1'h0, 1'b0, 4'h0);
    convert(0, 1'h0, 1'h0, 1'b1, 4'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
